// File: rtl/rbc_bg_lut.sv
// bandgap level lookup in millivolts
`include "rbc_defines.svh"
module rbc_bg_lut
  import rbc_pkg::*;
(
  input wire logic [3:0] i_code,
  output logic [`RBC_BG_W-1:0] o_mv
);
  always_comb begin
    unique case (i_code) // (RULE2)
      4'h0: o_mv = `RBC_BG_BASE_MV;
      4'h1: o_mv = 11'h4CB;
      4'h2: o_mv = 11'h4E5;
      4'h3: o_mv = 11'h500;
      4'h4: o_mv = 11'h51B;
      4'h5: o_mv = 11'h536;
      4'h6: o_mv = 11'h550;
      4'h7: o_mv = 11'h56B;
      4'h8: o_mv = 11'h586;
      4'h9: o_mv = 11'h5A0;
      4'hA: o_mv = 11'h5BB;
      4'hB: o_mv = 11'h5D6;
      4'hC: o_mv = 11'h5F0;
      4'hD: o_mv = 11'h60B;
      4'hE: o_mv = 11'h626;
      4'hF: o_mv = `RBC_BG_TOP_MV;
    endcase
  end
endmodule // rbc_bg_lut

// File: rtl/rbc_defines.svh
// register offsets, field positions, reset values and code widths for the reference and bias bank
`ifndef RBC_DEFINES_SVH
`define RBC_DEFINES_SVH
`define RBC_ADDR_W 8
`define RBC_DATA_W 16
`define RBC_OFF_PM1 8'h02
`define RBC_OFF_ARC 8'h07
`define RBC_OFF_REG_CODES 8'h40
`define RBC_OFF_STATUS 8'h41
`define RBC_PM1_MASK 16'h000F
`define RBC_ARC_MASK 16'h0FF0
`define RBC_CODES_MASK 16'h61FF
`define RBC_PM1_RESET 16'h0000
`define RBC_ARC_RESET 16'h0000
`define RBC_CODES_RESET 16'h0147
`define RBC_BIT_VBUF 2
`define RBC_BIT_BIAS 3
`define RBC_BIT_MID_EN 4
`define RBC_BIT_SLEW_LO 5
`define RBC_BIT_SRC 7
`define RBC_BIT_SUB 8
`define RBC_BIT_RATIO 9
`define RBC_BIT_MSRC 10
`define RBC_BIT_FAST 11
`define RBC_BIT_BG_LO 5
`define RBC_BIT_FREF 14
`define RBC_BIT_RREF 13
`define RBC_MULT_W 10
`define RBC_BG_W 11
`define RBC_BG_BASE_MV 11'h4B0
`define RBC_BG_TOP_MV 11'h640
`endif

// File: rtl/rbc_mult_lut.sv
// regulator multiplier lookup, hundredths of the chosen reference
`include "rbc_defines.svh"
module rbc_mult_lut
  import rbc_pkg::*;
(
  input wire logic [4:0] i_code,
  output logic [`RBC_MULT_W-1:0] o_mult
);
  // one fixed multiplier per code
  always_comb begin
    unique case (i_code) // (RULE1)
      5'h00: o_mult = 10'h08E;
      5'h01: o_mult = 10'h096;
      5'h02: o_mult = 10'h09E;
      5'h03: o_mult = 10'h0A6;
      5'h04: o_mult = 10'h0AE;
      5'h05: o_mult = 10'h0B6;
      5'h06: o_mult = 10'h0BE;
      5'h07: o_mult = 10'h0C5;
      5'h08: o_mult = 10'h0CE;
      5'h09: o_mult = 10'h0D5;
      5'h0A: o_mult = 10'h0DD;
      5'h0B: o_mult = 10'h0E5;
      5'h0C: o_mult = 10'h0ED;
      5'h0D: o_mult = 10'h0F5;
      5'h0E: o_mult = 10'h0FD;
      5'h0F: o_mult = 10'h10D;
      5'h10: o_mult = 10'h11D;
      5'h11: o_mult = 10'h12C;
      5'h12: o_mult = 10'h13C;
      5'h13: o_mult = 10'h14C;
      5'h14: o_mult = 10'h15D;
      5'h15: o_mult = 10'h16B;
      5'h16: o_mult = 10'h17B;
      5'h17: o_mult = 10'h18B;
      5'h18: o_mult = 10'h19C;
      5'h19: o_mult = 10'h1AC;
      5'h1A: o_mult = 10'h1BA;
      5'h1B: o_mult = 10'h1CA;
      5'h1C: o_mult = 10'h1DB;
      5'h1D: o_mult = 10'h1EA;
      5'h1E: o_mult = 10'h1FA;
      5'h1F: o_mult = 10'h20B;
    endcase
  end
endmodule // rbc_mult_lut

// File: rtl/rbc_pkg.sv
// types shared by the reference and bias bank
package rbc_pkg;
  typedef enum logic [1:0] {
    RBC_DIV_OFF = 2'h0,
    RBC_DIV_NORMAL = 2'h1,
    RBC_DIV_STANDBY = 2'h2,
    RBC_DIV_FAST = 2'h3
  } rbc_div_e;
  typedef enum logic [1:0] {
    RBC_SLEW_OFF = 2'h0,
    RBC_SLEW_FAST = 2'h1,
    RBC_SLEW_NORMAL = 2'h2,
    RBC_SLEW_SLOW = 2'h3
  } rbc_slew_e;
  typedef enum logic [2:0] {
    RBC_REF_BANDGAP = 3'h1,
    RBC_REF_MIDRAIL = 3'h2,
    RBC_REF_FASTSTART = 3'h4
  } rbc_ref_e;
endpackage

// File: rtl/rbc_top.sv
// reference and bias control register bank with decoded analogue controls
// Notes on behaviour
// (RULE1) five-bit regulator code maps to one fixed multiplier, 1.42 up to 5.23
// (RULE2) four-bit bandgap code maps to 1.200 V up to 1.600 V
// (RULE3) divider select: off, normal, standby, fast; resets to off
// (RULE4) midrail source bit 10: 0 regulator supply, 1 regulator output
// (RULE5) software keeps source at supply when midrail feeds the regulator
// (RULE6) ratio bit 9: 0 gives 5/11, 1 gives one half
// (RULE7) software aims for half regulator output, one half with output source
// (RULE8) midrail enable bit 4 with divider select gates midrail generation
// (RULE9) master bias bit 3 turns on normal bias; software also enables midrail
// (RULE10) startup bias bit 8 enables alternate bias; bit 7 picks source
// (RULE11) software uses startup bias while powering up, then normal
// (RULE12) soft-start field 6:5: off, fast, normal, slow; resets to off
// (RULE13) software enables soft-start and path before nonzero divider select
// (RULE14) soft shutdown sets slew, startup bias and source before divider off
// (RULE15) fast-start bit 11 enables supply-powered alternate midrail reference
// (RULE16) software enables bias along path before midrail is applied
// (RULE17) fast reference select only counts when regulator reference select is 0
// (RULE18) unassigned bits read zero and ignore writes; fields hold until reset
`include "rbc_defines.svh"
module rbc_top
  import rbc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [`RBC_ADDR_W-1:0] i_addr,
  input wire logic [`RBC_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [`RBC_DATA_W-1:0] o_rdata,
  output logic [1:0] o_midrail_divider_select,
  output logic o_midrail_on,
  output logic o_midrail_source_select,
  output logic o_midrail_ratio_select,
  output logic o_midrail_buffer_on,
  output logic o_master_bias_on,
  output logic o_startup_bias_on,
  output logic o_bias_source_select,
  output logic o_active_bias_on,
  output logic [1:0] o_soft_start_slew,
  output logic o_fast_start_reference_on,
  output logic [2:0] o_regulator_reference,
  output logic [`RBC_MULT_W-1:0] o_regulator_multiplier,
  output logic [`RBC_BG_W-1:0] o_bandgap_level_mv
);
  logic [`RBC_DATA_W-1:0] pm1_r;
  logic [`RBC_DATA_W-1:0] arc_r;
  logic [`RBC_DATA_W-1:0] codes_r;
  logic [`RBC_DATA_W-1:0] rdata_r;
  logic [`RBC_DATA_W-1:0] rdata_nxt;
  logic [1:0] div_r;
  logic mid_on_r;
  logic msrc_r;
  logic ratio_r;
  logic vbuf_r;
  logic bias_r;
  logic sub_r;
  logic src_r;
  logic act_bias_r;
  logic [1:0] slew_r;
  logic fast_r;
  logic [2:0] ref_r;
  logic [`RBC_MULT_W-1:0] mult_r;
  logic [`RBC_BG_W-1:0] bg_r;
  logic [`RBC_MULT_W-1:0] mult_w;
  logic [`RBC_BG_W-1:0] bg_w;
  logic [2:0] ref_nxt;
  logic [`RBC_DATA_W-1:0] status_w;

  // register write merge keeps only assigned bits
  function automatic logic [`RBC_DATA_W-1:0] masked(input logic [`RBC_DATA_W-1:0] d,
                                                    input logic [`RBC_DATA_W-1:0] m);
    masked = d & m;
  endfunction

  wire hit_pm1 = (i_addr == `RBC_OFF_PM1);
  wire hit_arc = (i_addr == `RBC_OFF_ARC);
  wire hit_codes = (i_addr == `RBC_OFF_REG_CODES);
  wire hit_status = (i_addr == `RBC_OFF_STATUS);
  wire wr_pm1 = i_wr & hit_pm1;
  wire wr_arc = i_wr & hit_arc;
  wire wr_codes = i_wr & hit_codes;

  wire [1:0] div_w = pm1_r[1:0]; // (RULE3)
  wire [1:0] slew_w = arc_r[`RBC_BIT_SLEW_LO +: 2]; // (RULE12)
  wire mid_en_w = arc_r[`RBC_BIT_MID_EN];
  // midrail is generated only with the enable set and a divider chosen
  wire mid_on_w = mid_en_w & (div_w != RBC_DIV_OFF); // (RULE8)
  wire rref_w = codes_r[`RBC_BIT_RREF];
  wire fref_w = codes_r[`RBC_BIT_FREF];
  // bias actually flowing: the selected source must also be switched on
  wire act_bias_w = arc_r[`RBC_BIT_SRC] ? arc_r[`RBC_BIT_SUB] : pm1_r[`RBC_BIT_BIAS]; // (RULE10)
  assign status_w = {11'h000, act_bias_w, mid_on_w, ref_r};

  // fast select is ignored once the bandgap is chosen
  always_comb begin
    if (rref_w) begin // (RULE17)
      ref_nxt = RBC_REF_BANDGAP;
    end else if (fref_w) begin
      ref_nxt = RBC_REF_FASTSTART;
    end else begin
      ref_nxt = RBC_REF_MIDRAIL;
    end
  end

  rbc_mult_lut u_mult (
    .i_code(codes_r[4:0]),
    .o_mult(mult_w)
  );

  rbc_bg_lut u_bg (
    .i_code(codes_r[`RBC_BIT_BG_LO +: 4]),
    .o_mv(bg_w)
  );

  // unmapped addresses read as zero
  always_comb begin
    rdata_nxt = 16'h0000;
    if (i_rd) begin
      if (hit_pm1) begin
        rdata_nxt = pm1_r; // (RULE18)
      end else if (hit_arc) begin
        rdata_nxt = arc_r;
      end else if (hit_codes) begin
        rdata_nxt = codes_r;
      end else if (hit_status) begin
        rdata_nxt = status_w;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pm1_r <= `RBC_PM1_RESET;
      arc_r <= `RBC_ARC_RESET;
      codes_r <= `RBC_CODES_RESET;
    end else begin
      if (wr_pm1) begin
        pm1_r <= masked(i_wdata, `RBC_PM1_MASK); // (RULE18)
      end
      if (wr_arc) begin
        arc_r <= masked(i_wdata, `RBC_ARC_MASK); // (RULE18)
      end
      if (wr_codes) begin
        codes_r <= masked(i_wdata, `RBC_CODES_MASK);
      end
    end
  end

  // outputs registered once more so each leaves straight from a flop
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_r <= 16'h0000;
      div_r <= 2'h0;
      mid_on_r <= 1'b0;
      msrc_r <= 1'b0;
      ratio_r <= 1'b0;
      vbuf_r <= 1'b0;
      bias_r <= 1'b0;
      sub_r <= 1'b0;
      src_r <= 1'b0;
      act_bias_r <= 1'b0;
      slew_r <= 2'h0;
      fast_r <= 1'b0;
      ref_r <= RBC_REF_MIDRAIL;
      mult_r <= 10'h000;
      bg_r <= 11'h000;
    end else begin
      rdata_r <= rdata_nxt;
      div_r <= div_w; // (RULE3)
      mid_on_r <= mid_on_w; // (RULE8)
      msrc_r <= arc_r[`RBC_BIT_MSRC]; // (RULE4)
      ratio_r <= arc_r[`RBC_BIT_RATIO]; // (RULE6)
      vbuf_r <= pm1_r[`RBC_BIT_VBUF];
      bias_r <= pm1_r[`RBC_BIT_BIAS]; // (RULE9)
      sub_r <= arc_r[`RBC_BIT_SUB]; // (RULE10)
      src_r <= arc_r[`RBC_BIT_SRC]; // (RULE10)
      act_bias_r <= act_bias_w;
      slew_r <= slew_w; // (RULE12)
      fast_r <= arc_r[`RBC_BIT_FAST]; // (RULE15)
      ref_r <= ref_nxt; // (RULE17)
      mult_r <= mult_w; // (RULE1)
      bg_r <= bg_w; // (RULE2)
    end
  end

  assign o_rdata = rdata_r;
  assign o_midrail_divider_select = div_r;
  assign o_midrail_on = mid_on_r;
  assign o_midrail_source_select = msrc_r;
  assign o_midrail_ratio_select = ratio_r;
  assign o_midrail_buffer_on = vbuf_r;
  assign o_master_bias_on = bias_r;
  assign o_startup_bias_on = sub_r;
  assign o_bias_source_select = src_r;
  assign o_active_bias_on = act_bias_r;
  assign o_soft_start_slew = slew_r;
  assign o_fast_start_reference_on = fast_r;
  assign o_regulator_reference = ref_r;
  assign o_regulator_multiplier = mult_r;
  assign o_bandgap_level_mv = bg_r;

  // decoded outputs trail a write by two edges
  chk_div_follows: assert property (@(posedge i_clk) disable iff (i_rst) // (RULE3)
    wr_pm1 |-> ##2 o_midrail_divider_select == $past(i_wdata[1:0], 2))
    else $error("divider select not taken from write");
  chk_mid_gate: assert property (@(posedge i_clk) disable iff (i_rst) // (RULE8)
    o_midrail_on |-> $past(arc_r[4]) && $past(pm1_r[1:0]) != 2'h0)
    else $error("midrail on without enable and divider");
  chk_mid_makes: assert property (@(posedge i_clk) disable iff (i_rst) // (RULE8)
    $past(arc_r[4]) && $past(pm1_r[1:0]) != 2'h0 |-> o_midrail_on)
    else $error("midrail off with enable and divider");
  chk_src_bit: assert property (@(posedge i_clk) disable iff (i_rst) // (RULE4)
    wr_arc |-> ##2 o_midrail_source_select == $past(i_wdata[10], 2))
    else $error("source select bit mismatch");
  chk_ratio_bit: assert property (@(posedge i_clk) disable iff (i_rst) // (RULE6)
    wr_arc |-> ##2 o_midrail_ratio_select == $past(i_wdata[9], 2))
    else $error("ratio bit mismatch");
  chk_slew_field: assert property (@(posedge i_clk) disable iff (i_rst) // (RULE12)
    wr_arc |-> ##2 o_soft_start_slew == $past(i_wdata[6:5], 2))
    else $error("slew field mismatch");
  chk_bias_bits: assert property (@(posedge i_clk) disable iff (i_rst) // (RULE9)
    wr_pm1 ##1 !wr_pm1 |-> ##1 o_master_bias_on == $past(i_wdata[3], 2))
    else $error("master bias bit mismatch");
  chk_startup_bit: assert property (@(posedge i_clk) disable iff (i_rst) // (RULE10)
    wr_arc |-> ##2 o_startup_bias_on == $past(i_wdata[8], 2))
    else $error("startup bias bit mismatch");
  chk_srcsel_bit: assert property (@(posedge i_clk) disable iff (i_rst) // (RULE10)
    wr_arc |-> ##2 o_bias_source_select == $past(i_wdata[7], 2))
    else $error("bias source bit mismatch");
  chk_startup_sel: assert property (@(posedge i_clk) disable iff (i_rst) // (RULE10)
    o_bias_source_select && o_startup_bias_on |-> o_active_bias_on)
    else $error("startup bias selected but not active");
  chk_active_norm: assert property (@(posedge i_clk) disable iff (i_rst) // (RULE10)
    !o_bias_source_select |-> o_active_bias_on == o_master_bias_on)
    else $error("normal bias selected but activity differs");
  chk_fast_bit: assert property (@(posedge i_clk) disable iff (i_rst) // (RULE15)
    wr_arc |-> ##2 o_fast_start_reference_on == $past(i_wdata[11], 2))
    else $error("fast start bit mismatch");
  chk_ref_prio: assert property (@(posedge i_clk) disable iff (i_rst) // (RULE17)
    $past(rref_w) |-> o_regulator_reference == RBC_REF_BANDGAP)
    else $error("bandgap select not obeyed");
  chk_ref_fast: assert property (@(posedge i_clk) disable iff (i_rst) // (RULE17)
    $past(!rref_w && fref_w) |-> o_regulator_reference == RBC_REF_FASTSTART)
    else $error("fast reference select not obeyed");
  chk_ref_mid: assert property (@(posedge i_clk) disable iff (i_rst) // (RULE17)
    $past(!rref_w && !fref_w) |-> o_regulator_reference == RBC_REF_MIDRAIL)
    else $error("midrail reference not chosen");
  chk_mult_ends: assert property (@(posedge i_clk) disable iff (i_rst) // (RULE1)
    $past(codes_r[4:0]) == 5'h1F |-> o_regulator_multiplier == 10'h20B)
    else $error("top multiplier wrong");
  chk_mult_low: assert property (@(posedge i_clk) disable iff (i_rst) // (RULE1)
    $past(codes_r[4:0]) == 5'h00 |-> o_regulator_multiplier == 10'h08E)
    else $error("lowest multiplier wrong");
  chk_bg_ends: assert property (@(posedge i_clk) disable iff (i_rst) // (RULE2)
    $past(codes_r[8:5]) == 4'h0 |-> o_bandgap_level_mv == `RBC_BG_BASE_MV)
    else $error("lowest bandgap wrong");
  chk_bg_top: assert property (@(posedge i_clk) disable iff (i_rst) // (RULE2)
    $past(codes_r[8:5]) == 4'hF |-> o_bandgap_level_mv == `RBC_BG_TOP_MV)
    else $error("top bandgap wrong");

  // storage and read-back checks
  chk_rsvd_zero: assert property (@(posedge i_clk) disable iff (i_rst) // (RULE18)
    i_rd && hit_arc |=> (o_rdata & ~16'h0FF0) == 16'h0000)
    else $error("reserved bits read nonzero");
  chk_rsvd_pm1: assert property (@(posedge i_clk) disable iff (i_rst) // (RULE18)
    i_rd && hit_pm1 |=> (o_rdata & ~`RBC_PM1_MASK) == 16'h0000)
    else $error("reserved power bits read nonzero");
  chk_unmapped_rd: assert property (@(posedge i_clk) disable iff (i_rst) // (RULE18)
    i_rd && !hit_pm1 && !hit_arc && !hit_codes && !hit_status |=> o_rdata == 16'h0000)
    else $error("unmapped address read nonzero");
  chk_arc_hold: assert property (@(posedge i_clk) disable iff (i_rst) // (RULE18)
    !wr_arc |=> $stable(arc_r))
    else $error("reference control changed without write");
  chk_pm1_hold: assert property (@(posedge i_clk) disable iff (i_rst) // (RULE18)
    !wr_pm1 |=> $stable(pm1_r))
    else $error("power control changed without write");
  chk_codes_hold: assert property (@(posedge i_clk) disable iff (i_rst) // (RULE18)
    !wr_codes |=> $stable(codes_r))
    else $error("regulator codes changed without write");

  cov_startup: cover property (@(posedge i_clk) disable iff (i_rst)
    o_startup_bias_on && o_bias_source_select ##1 o_midrail_on);
  cov_shutdown: cover property (@(posedge i_clk) disable iff (i_rst)
    o_midrail_on && o_soft_start_slew != 2'h0 ##[1:20] !o_midrail_on);
  cov_fastref: cover property (@(posedge i_clk) disable iff (i_rst)
    o_regulator_reference == RBC_REF_FASTSTART);
  cov_half_output: cover property (@(posedge i_clk) disable iff (i_rst)
    o_midrail_source_select && o_midrail_ratio_select && o_regulator_reference == RBC_REF_BANDGAP);
  cov_all_on: cover property (@(posedge i_clk) disable iff (i_rst)
    o_midrail_on && o_fast_start_reference_on && o_soft_start_slew == RBC_SLEW_SLOW);
endmodule // rbc_top

// File: verif/tb_rbc_top.sv
// self-checking bench for the reference and bias register bank
`include "rbc_defines.svh"
module tb_rbc_top
  import rbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [`RBC_ADDR_W-1:0] i_addr = 8'h00;
  logic [`RBC_DATA_W-1:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [`RBC_DATA_W-1:0] o_rdata;
  logic [1:0] o_div, o_slew;
  logic [2:0] o_ref;
  logic o_mid_on, o_src, o_ratio, o_buf, o_mbias, o_sbias, o_bsrc, o_abias, o_fast;
  logic [`RBC_MULT_W-1:0] o_mult;
  logic [`RBC_BG_W-1:0] o_bg;
  int errors = 0;
  int total_checks = 0;
  // expected lookup contents, hundredths and millivolts
  logic [9:0] mult_tab [32] = '{142, 150, 158, 166, 174, 182, 190, 197, 206, 213, 221, 229, 237, 245, 253, 269,
    285, 300, 316, 332, 349, 363, 379, 395, 412, 428, 442, 458, 475, 490, 506, 523};
  logic [10:0] bg_tab [16] = '{1200, 1227, 1253, 1280, 1307, 1334, 1360, 1387, 1414, 1440, 1467, 1494, 1520,
    1547, 1574, 1600};

  rbc_top u_rbc_top (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_midrail_divider_select(o_div), .o_midrail_on(o_mid_on),
    .o_midrail_source_select(o_src), .o_midrail_ratio_select(o_ratio), .o_midrail_buffer_on(o_buf),
    .o_master_bias_on(o_mbias), .o_startup_bias_on(o_sbias), .o_bias_source_select(o_bsrc),
    .o_active_bias_on(o_abias), .o_soft_start_slew(o_slew), .o_fast_start_reference_on(o_fast),
    .o_regulator_reference(o_ref), .o_regulator_multiplier(o_mult), .o_bandgap_level_mv(o_bg));

  always #2 i_clk = ~i_clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // returns once the decoded outputs have taken the new value
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
  endtask

  // read data only in the cycle after the strobe, zero after that
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
    @(posedge i_clk);
    #1;
    chk(o_rdata, 16'h0000);
  endtask

  task automatic t_reset;
    chk(16'(o_mult), 16'h00C5);
    chk(16'(o_bg), 16'h05BB);
    chk(16'(o_ref), 16'h0002);
    chk(16'(o_div), 16'(RBC_DIV_OFF));
    chk(16'({o_src, o_ratio, o_mid_on, o_mbias}), 16'h0000);
    chk(16'(o_slew), 16'(RBC_SLEW_OFF));
    rd(`RBC_OFF_PM1, `RBC_PM1_RESET);
    rd(`RBC_OFF_ARC, `RBC_ARC_RESET);
    rd(`RBC_OFF_REG_CODES, `RBC_CODES_RESET);
    rd(`RBC_OFF_STATUS, 16'h0002);
  endtask

  task automatic t_mask;
    // bandgap feeds the regulator before the midrail moves to the output
    wr(`RBC_OFF_REG_CODES, 16'h2147);
    wr(`RBC_OFF_PM1, 16'hFFFF);
    wr(`RBC_OFF_ARC, 16'hFFFF);
    rd(`RBC_OFF_PM1, `RBC_PM1_MASK);
    rd(`RBC_OFF_ARC, `RBC_ARC_MASK);
    chk(16'({o_div, o_mid_on, o_src, o_ratio, o_buf}), 16'h003F);
    chk(16'({o_mbias, o_sbias, o_bsrc, o_abias, o_fast}), 16'h001F);
    chk(16'(o_slew), 16'(RBC_SLEW_SLOW));
    rd(`RBC_OFF_STATUS, 16'h0019);
  endtask

  task automatic t_divider;
    wr(`RBC_OFF_ARC, 16'h0010);
    for (int d = 0; d < 4; d++) begin
      wr(`RBC_OFF_PM1, 16'(d));
      chk(16'(o_div), 16'(d));
      chk(16'(o_mid_on), 16'(d != 0));
    end
    // divider alone must not bring the midrail up
    wr(`RBC_OFF_ARC, 16'h0000);
    chk(16'(o_mid_on), 16'h0000);
  endtask

  task automatic t_bias;
    logic [15:0] arc_v [4] = '{16'h0000, 16'h0100, 16'h0180, 16'h0080};
    logic [15:0] pm_v [4] = '{16'h0008, 16'h0000, 16'h0000, 16'h0008};
    logic abias_v [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    for (int k = 0; k < 4; k++) begin
      wr(`RBC_OFF_ARC, arc_v[k]);
      wr(`RBC_OFF_PM1, pm_v[k]);
      chk(16'(o_abias), 16'(abias_v[k]));
    end
    for (int s = 0; s < 4; s++) begin
      wr(`RBC_OFF_ARC, 16'(s) << 5);
      chk(16'(o_slew), 16'(s));
    end
    // soft-start before the divider; soft shutdown: slew and startup bias first, divider off last
    wr(`RBC_OFF_ARC, 16'h0070);
    wr(`RBC_OFF_PM1, 16'h0001);
    wr(`RBC_OFF_ARC, 16'h01F0);
    wr(`RBC_OFF_PM1, 16'h0000);
    chk(16'({o_div, o_slew, o_sbias, o_bsrc, o_abias}), 16'h001F);
  endtask

  // recommended power-up: startup bias and soft-start, then divider, normal bias last
  task automatic t_startup;
    wr(`RBC_OFF_ARC, 16'h09A0);
    chk(16'({o_sbias, o_bsrc, o_abias, o_mid_on}), 16'h000E);
    wr(`RBC_OFF_REG_CODES, 16'h4147);
    chk(16'({o_fast, o_ref}), 16'h000C);
    wr(`RBC_OFF_ARC, 16'h09B0);
    wr(`RBC_OFF_PM1, 16'h0001);
    rd(`RBC_OFF_STATUS, 16'h001C);
    wr(`RBC_OFF_PM1, 16'h0009);
    chk(16'({o_mbias, o_mid_on}), 16'h0003);
    wr(`RBC_OFF_ARC, 16'h0830);
    chk(16'({o_sbias, o_bsrc, o_abias}), 16'h0001);
    wr(`RBC_OFF_REG_CODES, 16'h0147);
    chk(16'({o_src, o_ref}), 16'h0002);
    wr(`RBC_OFF_REG_CODES, 16'h2147);
    wr(`RBC_OFF_ARC, 16'h0E30);
    chk(16'({o_src, o_ratio, o_ref}), 16'h0019);
    // back to the supply before later scenarios use the midrail reference
    wr(`RBC_OFF_ARC, 16'h0000);
  endtask

  task automatic t_luts;
    for (int i = 0; i < 32; i++) begin
      wr(`RBC_OFF_REG_CODES, 16'(i) | (16'(i % 16) << 5));
      chk(16'(o_mult), 16'(mult_tab[i]));
      chk(16'(o_bg), 16'(bg_tab[i % 16]));
    end
  endtask

  task automatic t_ref;
    logic [15:0] sel_v [4] = '{16'h0000, 16'h2000, 16'h4000, 16'h6000};
    logic [15:0] ref_v [4] = '{16'h0002, 16'h0001, 16'h0004, 16'h0001};
    for (int k = 0; k < 4; k++) begin
      wr(`RBC_OFF_REG_CODES, sel_v[k] | 16'h0147);
      chk(16'(o_ref), ref_v[k]);
    end
    rd(`RBC_OFF_REG_CODES, 16'h6147);
  endtask

  task automatic t_refuse;
    wr(`RBC_OFF_ARC, 16'h0A10);
    wr(8'h10, 16'hFFFF);
    rd(8'h10, 16'h0000);
    wr(`RBC_OFF_STATUS, 16'hFFFF);
    rd(`RBC_OFF_ARC, 16'h0A10);
    chk(16'({o_src, o_ratio}), 16'h0001);
    // second reset in mid-run brings every field back
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(`RBC_OFF_ARC, `RBC_ARC_RESET);
    rd(`RBC_OFF_REG_CODES, `RBC_CODES_RESET);
    chk(16'({o_ref, o_src, o_ratio, o_fast}), 16'h0010);
    chk(16'(o_mult), 16'h00C5);
  endtask

  task automatic test_done;
    if (errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // whole sequence needs well under two thousand cycles
  initial begin
    #40000;
    errors++;
    test_done();
  end

  initial begin
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    t_reset();
    t_mask();
    t_divider();
    t_bias();
    t_startup();
    t_luts();
    t_ref();
    t_refuse();
    test_done();
  end
endmodule // tb_rbc_top
